// [trace_jtag_access.v]
// Trace macrocell register file reached only through a test access port scan chain.
// Assumes tck, tms, tdi and trst_n come from pins; core_clk runs well above the test clock.
// Overview of operation
// RQ1 - Trace registers are reachable only through the test access port, with no other access.
// RQ2 - The access path is scan chain 6, which the host selects through the chain select register.
// RQ3 - The selected chain is 40 bits: 32 data bits, 7 address bits and one read/write bit.
// RQ4 - A write request carries data, register number and a one in the read/write bit.
// RQ5 - A read request carries the register number and a zero; its data field is ignored.
// RQ6 - The register access happens only on entry to Update-DR, never while shifting; the code acts on the rising test clock edge that leaves Update-DR.
// RQ7 - A read result is loaded into the data field at the next Capture-DR for shifting out.
`timescale 1ns/1ps
`default_nettype none
`include "trace_jtag_defines.vh"

module trace_jtag_access (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        tck,
    input  wire        tms,
    input  wire        tdi,
    input  wire        trst_n,
    output reg         tdo,
    output reg         tdo_oe,
    output reg  [31:0] ctrl_word,
    output reg         reg_wr_pulse,
    output reg  [6:0]  reg_wr_addr
);

    // Each pin passes two flip-flops before any logic reads it.
    // In reset the test clock bank holds low and the mode bank high, so no false
    // edge follows reset; the test reset bank holds low to keep the port in reset.
    wire [`PIN_N-1:0] pin_raw;
    wire [`PIN_N-1:0] pin_sync;
    wire [`PIN_N-1:0] pin_idle = `PIN_IDLE;
    reg               tck_d_r;

    assign pin_raw[`PIN_TCK]  = tck;
    assign pin_raw[`PIN_TMS]  = tms;
    assign pin_raw[`PIN_TDI]  = tdi;
    assign pin_raw[`PIN_TRST] = trst_n;

    genvar g;
    generate
        for (g = 0; g < `PIN_N; g = g + 1) begin : g_sync
            reg meta_r;
            reg hold_r;
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    meta_r <= pin_idle[g];
                    hold_r <= pin_idle[g];
                end else begin
                    meta_r <= pin_raw[g];
                    hold_r <= meta_r;
                end
            end
            assign pin_sync[g] = hold_r;
        end
    endgenerate

    // Edge finder on the synchronised test clock; each edge lasts one core cycle.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            tck_d_r <= 1'b0;
        end else begin
            tck_d_r <= pin_sync[`PIN_TCK];
        end
    end

    wire tck_rise  = pin_sync[`PIN_TCK] & ~tck_d_r;
    wire tck_fall  = ~pin_sync[`PIN_TCK] & tck_d_r;
    wire tms_q     = pin_sync[`PIN_TMS];
    wire tdi_q     = pin_sync[`PIN_TDI];
    // The test reset pin clears the port logic only; the register file keeps its contents.
    wire tap_rst_n = rst_n & pin_sync[`PIN_TRST];

    // True in the two shift states, in which the port drives its data out pin.
    function in_shift;
        input [3:0] st;
        begin
            in_shift = (st == `TS_SHIFT_DR) || (st == `TS_SHIFT_IR);
        end
    endfunction

    wire [3:0] tap_state;

    tap_state_tracker u_tap (
        .core_clk (core_clk),
        .rst_n    (tap_rst_n),
        .tck_rise (tck_rise),
        .tms_s    (tms_q),
        .state_r  (tap_state)
    );

    reg [3:0]                  ir_sh_r;
    reg [3:0]                  ir_r;
    reg [`SCAN_SEL_W-1:0]      sel_sh_r;
    reg [`SCAN_SEL_W-1:0]      chain_r;
    reg [`CHAIN_W-1:0]         dr_sh_r;
    reg                        bypass_r;
    reg [`DATA_W-1:0]          regs_r [0:`NUM_REGS-1];
    reg [`DATA_W-1:0]          rd_data_r;
    reg                        rd_pend_r;

    // Any other chain, or any instruction other than SCAN_N and INTEST, falls through to the one-bit bypass path,
    // so requests shifted while the trace chain is not selected change nothing.
    wire trace_sel = (ir_r == `IR_INTEST) && (chain_r == `TRACE_CHAIN); // RQ2
    wire scan_n    = (ir_r == `IR_SCAN_N);

    wire [`ADDR_W-1:0] req_addr = dr_sh_r[`ADDR_MSB:`ADDR_LSB];
    wire               req_wr   = dr_sh_r[`RW_BIT];

    always @(posedge core_clk) begin
        if (!tap_rst_n) begin
            ir_sh_r   <= {`IR_W{1'b0}};
            ir_r      <= `IR_INTEST;
            sel_sh_r  <= {`SCAN_SEL_W{1'b0}};
            chain_r   <= {`SCAN_SEL_W{1'b0}};
            dr_sh_r   <= {`CHAIN_W{1'b0}};
            bypass_r  <= 1'b0;
            rd_data_r <= {`DATA_W{1'b0}};
            rd_pend_r <= 1'b0;
        end else if (tck_rise) begin
            case (tap_state)
                `TS_CAP_IR: begin
                    ir_sh_r <= `IR_CAPTURE;
                end
                `TS_SHIFT_IR: begin
                    ir_sh_r <= {tdi_q, ir_sh_r[`IR_W-1:1]};
                end
                `TS_UPD_IR: begin
                    ir_r <= ir_sh_r;
                end
                `TS_CAP_DR: begin
                    bypass_r <= 1'b0;
                    sel_sh_r <= chain_r;
                    if (trace_sel) begin
                        dr_sh_r[`DATA_W-1:0] <= rd_pend_r ? rd_data_r : dr_sh_r[`DATA_W-1:0]; // RQ7
                        rd_pend_r            <= 1'b0;
                    end
                end
                `TS_SHIFT_DR: begin
                    // Shifting only moves bits; no register is touched here.
                    if (scan_n) begin
                        sel_sh_r <= {tdi_q, sel_sh_r[`SCAN_SEL_W-1:1]};
                    end else if (trace_sel) begin
                        dr_sh_r <= {tdi_q, dr_sh_r[`CHAIN_W-1:1]}; // RQ3 RQ6
                    end else begin
                        bypass_r <= tdi_q;
                    end
                end
                `TS_UPD_DR: begin
                    // A read result is held until the next capture, so the host may
                    // idle or pause as long as it likes between the two scans.
                    if (scan_n) begin
                        chain_r <= sel_sh_r; // RQ2
                    end else if (trace_sel && !req_wr) begin
                        rd_data_r <= regs_r[req_addr]; // RQ5 RQ6
                        rd_pend_r <= 1'b1;
                    end
                end
                default: begin
                    ir_sh_r <= ir_sh_r;
                end
            endcase
        end
    end

    // Register array written only from Update-DR of the trace chain.
    wire do_write = tck_rise && (tap_state == `TS_UPD_DR) && trace_sel && req_wr; // RQ1 RQ4 RQ6

    integer i;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            for (i = 0; i < `NUM_REGS; i = i + 1) begin
                regs_r[i] <= {`DATA_W{1'b0}};
            end
        end else if (do_write) begin
            regs_r[req_addr] <= dr_sh_r[`DATA_W-1:0];
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            reg_wr_pulse <= 1'b0;
            reg_wr_addr  <= {`ADDR_W{1'b0}};
            ctrl_word    <= {`DATA_W{1'b0}};
        end else begin
            reg_wr_pulse <= do_write;
            if (do_write) begin
                reg_wr_addr <= req_addr;
                if (req_addr == {`ADDR_W{1'b0}}) begin
                    ctrl_word <= dr_sh_r[`DATA_W-1:0];
                end
            end
        end
    end

    // Output changes on the falling test clock edge, as the host samples at the end of the high phase, before the next fall.
    always @(posedge core_clk) begin
        if (!tap_rst_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= in_shift(tap_state);
            if (tap_state == `TS_SHIFT_IR) begin
                tdo <= ir_sh_r[0];
            end else if (scan_n) begin
                tdo <= sel_sh_r[0];
            end else if (trace_sel) begin
                tdo <= dr_sh_r[0];
            end else begin
                tdo <= bypass_r;
            end
        end
    end

endmodule

`default_nettype wire

// [trace_jtag_defines.vh]
// Constants for the trace register access scan chain.
// Assumes inclusion by bare name from the design files of this block.
`ifndef TRACE_JTAG_DEFINES_VH
`define TRACE_JTAG_DEFINES_VH

`define CHAIN_W        40
`define DATA_W         32
`define ADDR_W         7
`define ADDR_LSB       32
`define ADDR_MSB       38
`define RW_BIT         39
`define SCAN_SEL_W     4
`define TRACE_CHAIN    4'h6
`define IR_W           4
`define IR_SCAN_N      4'h2
`define IR_INTEST      4'hC
`define NUM_REGS       128
`define IR_CAPTURE     4'h1

`define PIN_N          4
`define PIN_TCK        0
`define PIN_TMS        1
`define PIN_TDI        2
`define PIN_TRST       3
`define PIN_IDLE       4'h2

`define TS_RESET       4'h0
`define TS_IDLE        4'h1
`define TS_SEL_DR      4'h2
`define TS_CAP_DR      4'h3
`define TS_SHIFT_DR    4'h4
`define TS_EXIT1_DR    4'h5
`define TS_PAUSE_DR    4'h6
`define TS_EXIT2_DR    4'h7
`define TS_UPD_DR      4'h8
`define TS_SEL_IR      4'h9
`define TS_CAP_IR      4'hA
`define TS_SHIFT_IR    4'hB
`define TS_EXIT1_IR    4'hC
`define TS_PAUSE_IR    4'hD
`define TS_EXIT2_IR    4'hE
`define TS_UPD_IR      4'hF

`endif

// [tap_state_tracker.v]
// TAP controller state machine advanced once per rising test clock edge.
// Assumes the caller supplies a one-cycle rising-edge strobe and a synchronised mode level.
`timescale 1ns/1ps
`default_nettype none
`include "trace_jtag_defines.vh"

module tap_state_tracker (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       tck_rise,
    input  wire       tms_s,
    output reg  [3:0] state_r
);

    reg [3:0] state_nxt;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            `TS_RESET:    state_nxt = tms_s ? `TS_RESET    : `TS_IDLE;
            `TS_IDLE:     state_nxt = tms_s ? `TS_SEL_DR   : `TS_IDLE;
            `TS_SEL_DR:   state_nxt = tms_s ? `TS_SEL_IR   : `TS_CAP_DR;
            `TS_CAP_DR:   state_nxt = tms_s ? `TS_EXIT1_DR : `TS_SHIFT_DR;
            `TS_SHIFT_DR: state_nxt = tms_s ? `TS_EXIT1_DR : `TS_SHIFT_DR;
            `TS_EXIT1_DR: state_nxt = tms_s ? `TS_UPD_DR   : `TS_PAUSE_DR;
            `TS_PAUSE_DR: state_nxt = tms_s ? `TS_EXIT2_DR : `TS_PAUSE_DR;
            `TS_EXIT2_DR: state_nxt = tms_s ? `TS_UPD_DR   : `TS_SHIFT_DR;
            `TS_UPD_DR:   state_nxt = tms_s ? `TS_SEL_DR   : `TS_IDLE;
            `TS_SEL_IR:   state_nxt = tms_s ? `TS_RESET    : `TS_CAP_IR;
            `TS_CAP_IR:   state_nxt = tms_s ? `TS_EXIT1_IR : `TS_SHIFT_IR;
            `TS_SHIFT_IR: state_nxt = tms_s ? `TS_EXIT1_IR : `TS_SHIFT_IR;
            `TS_EXIT1_IR: state_nxt = tms_s ? `TS_UPD_IR   : `TS_PAUSE_IR;
            `TS_PAUSE_IR: state_nxt = tms_s ? `TS_EXIT2_IR : `TS_PAUSE_IR;
            `TS_EXIT2_IR: state_nxt = tms_s ? `TS_UPD_IR   : `TS_SHIFT_IR;
            default:      state_nxt = tms_s ? `TS_SEL_DR   : `TS_IDLE;
        endcase
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= `TS_RESET;
        end else if (tck_rise) begin
            state_r <= state_nxt;
        end
    end

endmodule

`default_nettype wire

// [trace_jtag_monitor.sv]
// Port checks for the trace register access block.
// Assumes it is bound to trace_jtag_access.
`timescale 1ns/1ps
`default_nettype none
module trace_jtag_monitor (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        tck,
    input wire logic        tdo,
    input wire logic        tdo_oe,
    input wire logic [31:0] ctrl_word,
    input wire logic        reg_wr_pulse,
    input wire logic [6:0]  reg_wr_addr
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_commit;
        reg_wr_pulse ##1 !reg_wr_pulse;
    endsequence
    a_pulse_once: assert property (reg_wr_pulse |-> s_commit)
        else $error("long pulse");
    a_no_shift_wr: assert property (reg_wr_pulse |-> !tdo_oe && !$past(tdo_oe, 4))
        else $error("write while shifting");
    a_ctrl_cause: assert property (!$stable(ctrl_word) |->
        ##[0:1] (reg_wr_pulse && reg_wr_addr == 7'h00)) else $error("ctrl change");
    a_addr_cause: assert property (!$stable(reg_wr_addr) |-> ##[0:1] reg_wr_pulse)
        else $error("addr change");
    a_oe_on_fall: assert property (!$stable(tdo_oe) |-> !tck)
        else $error("oe edge");
    a_tdo_on_fall: assert property (!$stable(tdo) |-> !tck)
        else $error("tdo edge");
endmodule
bind trace_jtag_access trace_jtag_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n),
    .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe), .ctrl_word(ctrl_word),
    .reg_wr_pulse(reg_wr_pulse), .reg_wr_addr(reg_wr_addr));
`default_nettype wire

// [jtag_host.sv]
// Behavioural test-port host driving the test clock, mode and data pins.
// Assumes calls start just after a core_clk edge; four core cycles per tck phase.
`timescale 1ns/1ps
`default_nettype none
module jtag_host (
    input  wire logic core_clk,
    input  wire logic tdo,
    output var logic  tck,
    output var logic  tms,
    output var logic  tdi
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Pins change at the fall and hold over the rise; tdo is taken before the next fall.
    task automatic step(input logic m, input logic d, output logic o);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge core_clk);
        tck <= 1'b1;
        repeat (4) @(posedge core_clk);
        o = tdo;
    endtask
    task automatic scan(input logic ir, input int n, input logic [39:0] din,
                        output logic [39:0] dout);
        logic o;
        dout = 40'h0;
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask
endmodule
`default_nettype wire

// [trace_jtag_access_tb.sv]
// Self-checking bench for the trace register access block.
// Assumes jtag_host drives the test pins and the monitor is bound to the design.
`timescale 1ns/1ps
`default_nettype none
module trace_jtag_access_tb;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        trst_n = 1'b0;
    wire         tck, tms, tdi, tdo, tdo_oe, reg_wr_pulse;
    wire  [31:0] ctrl_word;
    wire  [6:0]  reg_wr_addr;
    logic [31:0] mem [128];
    logic [31:0] seed = 32'hEBB28363;
    int          bad_count = 0;
    int          checks = 0;
    int          pulses = 0;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) if (reg_wr_pulse === 1'b1) pulses <= pulses + 1;
    jtag_host host (.core_clk(core_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
    trace_jtag_access uut (.core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .ctrl_word(ctrl_word),
        .reg_wr_pulse(reg_wr_pulse), .reg_wr_addr(reg_wr_addr));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #1500000;
        bad_count++;
        finish_test();
    end
    initial begin
        logic [39:0] r;
        logic [31:0] d;
        logic [6:0]  a;
        logic        o;
        int          nwr;
        nwr = 0;
        foreach (mem[k]) mem[k] = 32'h0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        trst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        host.step(1'b0, 1'b0, o);
        // A write before the chain is selected must be ignored.
        host.scan(1'b0, 40, {1'b1, 7'h00, 32'hA5A5A5A5}, r);
        chk(ctrl_word, 32'h0);
        host.scan(1'b1, 4, 40'h2, r);
        chk({28'h0, r[3:0]}, 32'h1);
        host.scan(1'b0, 4, 40'h6, r);
        host.scan(1'b1, 4, 40'hC, r);
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            a = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : d[6:0];
            d = rnd();
            host.scan(1'b0, 40, {1'b1, a, d}, r);
            mem[a] = d;
            nwr++;
            chk({25'h0, reg_wr_addr}, {25'h0, a});
            chk(ctrl_word, mem[0]);
            host.scan(1'b0, 40, {1'b0, a, ~d}, r);
            host.scan(1'b0, 40, {1'b0, a, rnd()}, r);
            chk(r[31:0], d);
            chk(ctrl_word, mem[0]);
        end
        chk(pulses, nwr);
        finish_test();
    end
endmodule
`default_nettype wire
